// ---- design/rfc_pkg.sv ----
// Package for the RF conditioning front end: register map, fields, carriers.
package rfc_pkg;
  localparam logic [31:0] BASE_ADDR = 32'h3000_0000;
  localparam logic [11:0] OWN_LAST = 12'h24c;
  localparam logic [11:0] HOSTED_FIRST = 12'h2a0;
  localparam logic [11:0] HOSTED_LAST = 12'h374;
  localparam int HOSTED_WORDS = 54;
  // Own register offsets
  localparam logic [11:0] SAMPLE_CFG = 12'h000;
  localparam logic [11:0] DC_REJECT_FILTER_CTRL = 12'h004;
  localparam logic [11:0] PEAK_MEAS_BANDWIDTH = 12'h008;
  localparam logic [11:0] FLAW_PATH_BANDWIDTH = 12'h00c;
  localparam logic [11:0] LEVEL_LOOPS_CTRL = 12'h010;
  localparam logic [11:0] GAIN_THR_LO = 12'h014;
  localparam logic [11:0] GAIN_THR_HI = 12'h018;
  localparam logic [11:0] OFFSET_BOUND = 12'h01c;
  localparam logic [11:0] GAIN_SETTING = 12'h020;
  localparam logic [11:0] OFFSET_COMP = 12'h024;
  localparam logic [11:0] MEAS_MAX = 12'h030;
  localparam logic [11:0] MEAS_MIN = 12'h034;
  localparam logic [11:0] MEAS_AMPLITUDE = 12'h038;
  localparam logic [11:0] MEAS_OFFSET = 12'h03c;
  localparam logic [11:0] WIN_MAX = 12'h040;
  localparam logic [11:0] WIN_MIN = 12'h044;
  localparam logic [11:0] HPF_SAMPLE = 12'h048;
  localparam logic [11:0] LATCHED_EVENT_FLAGS = 12'h050;
  localparam logic [11:0] LATCHED_EVENT_MASK = 12'h054;
  localparam logic [11:0] LIVE_EVENT_FLAGS = 12'h058;
  localparam logic [11:0] LIVE_EVENT_MASK = 12'h05c;
  // Field positions
  localparam int CUTOFF_MSB = 5;
  localparam int HPF_RESET_BIT = 6;
  localparam int HPF_HOLD_BIT = 7;
  localparam int RELEASE_MSB = 3;
  localparam int NOISE_LSB = 4;
  localparam int NOISE_MSB = 6;
  localparam int WINDOW_MSB = 3;
  localparam int GAIN_LOOP_BIT = 4;
  localparam int OFFSET_LOOP_BIT = 5;
  // Latched flags: window done, flaw start, gain step, offset step; live: flaw, meas new
  localparam int EV_WINDOW = 0;
  localparam int EV_FLAW_RISE = 1;
  localparam int EV_GAIN_STEP = 2;
  localparam int EV_OFS_STEP = 3;
  localparam int LV_FLAW = 0;
  localparam int LV_MEAS_NEW = 1;
  // Reset values
  localparam logic [2:0] SAMPLE_CFG_RST = 3'h0;
  localparam logic [7:0] HPF_CTRL_RST = 8'h04;
  localparam logic [7:0] BW_RST = 8'h04;
  localparam logic [7:0] LOOPS_RST = 8'h04;
  localparam logic [7:0] THR_LO_RST = 8'h40;
  localparam logic [7:0] THR_HI_RST = 8'h80;
  localparam logic [7:0] OFS_BOUND_RST = 8'h08;
  localparam logic [3:0] GAIN_RST = 4'h8;
  // Integrate-and-dump limits and release settings
  localparam logic [2:0] SAMPLE_DIV_MAX = 3'h4;
  localparam logic [4:0] RELEASE_M_BASE = 5'h06;
  localparam int REL_FRAC = 21;
  localparam int HPF_FRAC = 11;
  localparam logic signed [29:0] RELEASE_FLOOR = 30'sh3000_0000;
  localparam logic signed [29:0] RELEASE_CEIL = 30'sh0fe0_0000;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rfc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rfc_wb_rsp_t;

  typedef struct packed {
    logic [3:0] gain_code;
    logic signed [5:0] offset_code;
  } rfc_analog_t;
endpackage

// ---- design/rfc_frontend.sv ----
// RF conditioning front end: sample averaging, DC reject, peak detection, level loops.
module rfc_frontend import rfc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register bus
  input wire rfc_wb_req_t wb_req,
  output rfc_wb_rsp_t wb_rsp,
  // Converter samples, one per clock
  input wire logic [5:0] sample_in,
  input wire logic flaw_detected,
  // Conditioned stream at system rate
  output logic sys_tick,
  output logic signed [7:0] hpf_out,
  output logic [7:0] flaw_amplitude,
  // Analog control and hosted registers
  output rfc_analog_t analog_ctrl,
  output logic [HOSTED_WORDS*8-1:0] hosted_regs,
  output logic irq_n
);

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [2:0] sample_cfg;
    logic [7:0] hpf_ctrl;
    logic [7:0] meas_bw;
    logic [7:0] flaw_bw;
    logic [7:0] loops_ctrl;
    logic [7:0] thr_lo;
    logic [7:0] thr_hi;
    logic [7:0] ofs_bound;
    logic [3:0] gain;
    logic signed [5:0] ofs_comp;
    logic [4:0] ic_cnt;
    logic [10:0] ic_sum;
    logic tick;
    logic signed [7:0] x;
    logic signed [19:0] lp_acc;
    logic signed [7:0] hpf_q;
    logic signed [15:0] nf_meas;
    logic signed [15:0] nf_flaw;
    logic signed [28:0] mx_meas;
    logic signed [28:0] mn_meas;
    logic signed [28:0] mx_flaw;
    logic signed [28:0] mn_flaw;
    logic [15:0] win_cnt;
    logic signed [7:0] win_hi;
    logic signed [7:0] win_lo;
    logic signed [7:0] win_max;
    logic signed [7:0] win_min;
    logic flaw_prev;
    logic [3:0] lat_flags;
    logic [3:0] lat_mask;
    logic [1:0] live_flags;
    logic [1:0] live_mask;
    logic irq_n;
    logic [HOSTED_WORDS*8-1:0] hosted;
  } rfc_state_t;

  rfc_state_t st;
  rfc_state_t next_st;

  // Noise low-pass in 8.8 form; zero bandwidth code bypasses the filter
  function automatic logic signed [15:0] noise_step(input logic signed [15:0] s,
      input logic signed [7:0] x, input logic [2:0] bw);
    logic signed [16:0] d;
    d = {x[7], x, 8'h00} - {s[15], s};
    if (bw == 3'h0) return {x, 8'h00};
    return s + 16'(d >>> bw);
  endfunction

  // Instant attack, release by 2^-m per tick toward the far end of the range
  function automatic logic signed [28:0] release_step(input logic signed [28:0] acc,
      input logic signed [7:0] x, input logic [3:0] bw, input logic is_max);
    logic signed [28:0] xa;
    logic signed [29:0] d;
    xa = {x, 21'h0};
    // Shift a signed value so the minimum path keeps its sign while releasing
    d = $signed({acc[28], acc}) - (is_max ? RELEASE_FLOOR : RELEASE_CEIL);
    d = d >>> ({1'b0, bw} + RELEASE_M_BASE);
    // An equal sample holds the peak, so a steady input reads back steady
    if (is_max ? (xa >= acc) : (xa <= acc)) return xa;
    return 29'({acc[28], acc} - d);
  endfunction

  function automatic logic [7:0] sat_u8(input logic signed [8:0] v);
    return v[8] ? 8'h00 : v[7:0];
  endfunction

  logic bus_req;
  logic bus_done;
  logic [11:0] off;
  logic in_range;
  logic hosted_hit;
  logic [5:0] hosted_idx;
  logic [7:0] wbyte;
  logic signed [7:0] mmax;
  logic signed [7:0] mmin;
  logic signed [8:0] mamp;
  logic signed [8:0] msum;
  logic signed [8:0] wamp;
  logic signed [8:0] wsum;
  logic win_end;
  logic [12:0] avg_wide;
  logic signed [9:0] lp_dlt;
  logic signed [16:0] lp_prod;
  logic signed [9:0] hp_raw;

  assign bus_req = wb_req.cyc & wb_req.stb;
  assign bus_done = bus_req & st.ack;
  assign off = wb_req.adr[11:0];
  assign in_range = (wb_req.adr[31:12] == BASE_ADDR[31:12]) && (off <= HOSTED_LAST);
  assign hosted_hit = in_range && (off >= HOSTED_FIRST);
  assign hosted_idx = 6'((off - HOSTED_FIRST) >> 2);
  assign wbyte = wb_req.dat[7:0];
  assign mmax = st.mx_meas[28:21];
  assign mmin = st.mn_meas[28:21];
  assign mamp = {mmax[7], mmax} - {mmin[7], mmin};
  assign msum = {mmax[7], mmax} + {mmin[7], mmin};
  assign wamp = {st.win_max[7], st.win_max} - {st.win_min[7], st.win_min};
  assign wsum = {st.win_max[7], st.win_max} + {st.win_min[7], st.win_min};
  assign win_end = st.tick && (st.win_cnt == 16'((17'h1 << st.loops_ctrl[WINDOW_MSB:0]) - 1));

  always_comb begin
    logic [4:0] last;
    logic [2:0] div;
    logic [10:0] sum;
    logic [7:0] rd;
    logic signed [7:0] nm;
    logic signed [7:0] nf;
    logic [3:0] lat_set;
    logic [3:0] lat_clr;
    logic [1:0] live_clr;
    last = 5'h0;
    div = 3'h0;
    sum = 11'h0;
    rd = 8'h00;
    nm = 8'sh00;
    nf = 8'sh00;
    lat_set = 4'h0;
    lat_clr = 4'h0;
    live_clr = 2'h0;
    next_st = st;
    avg_wide = 13'h0;
    lp_dlt = 10'sh000;
    lp_prod = 17'sh00000;
    hp_raw = 10'sh000;

    // System rate is two fast cycles or more; averaged in the same step
    div = (st.sample_cfg > SAMPLE_DIV_MAX) ? SAMPLE_DIV_MAX : st.sample_cfg;
    last = 5'((6'h1 << (div + 3'h1)) - 6'h1);
    sum = st.ic_sum + {5'h00, sample_in};
    next_st.tick = 1'b0;
    if (st.ic_cnt >= last) begin
      avg_wide = {sum, 2'b00} >> (div + 3'h1);
      next_st.x = $signed(avg_wide[7:0] ^ 8'h80);
      next_st.tick = 1'b1;
      next_st.ic_cnt = 5'h00;
      next_st.ic_sum = 11'h000;
    end else begin
      next_st.ic_cnt = st.ic_cnt + 5'h01;
      next_st.ic_sum = sum;
    end

    // The filters, peak detectors and window in this block advance once per system tick
    if (st.tick) begin
      lp_dlt = {{2{st.x[7]}}, st.x} - {st.lp_acc[19], st.lp_acc[19:HPF_FRAC]};
      lp_prod = lp_dlt * $signed({1'b0, st.hpf_ctrl[CUTOFF_MSB:0]});
      if (!(flaw_detected && st.hpf_ctrl[HPF_HOLD_BIT])) begin
        next_st.lp_acc = st.lp_acc + {{3{lp_prod[16]}}, lp_prod};
      end
      hp_raw = {{2{st.x[7]}}, st.x} - {st.lp_acc[19], st.lp_acc[19:HPF_FRAC]};
      if (hp_raw > 10'sd127) next_st.hpf_q = 8'sh7f;
      else if (hp_raw < -10'sd128) next_st.hpf_q = 8'sh80;
      else next_st.hpf_q = hp_raw[7:0];

      next_st.nf_meas = noise_step(st.nf_meas, st.x, st.meas_bw[NOISE_MSB:NOISE_LSB]);
      next_st.nf_flaw = noise_step(st.nf_flaw, st.x, st.flaw_bw[NOISE_MSB:NOISE_LSB]);
      nm = st.nf_meas[15:8];
      nf = st.nf_flaw[15:8];
      next_st.mx_meas = release_step(st.mx_meas, nm, st.meas_bw[RELEASE_MSB:0], 1'b1);
      next_st.mn_meas = release_step(st.mn_meas, nm, st.meas_bw[RELEASE_MSB:0], 1'b0);
      next_st.mx_flaw = release_step(st.mx_flaw, nf, st.flaw_bw[RELEASE_MSB:0], 1'b1);
      next_st.mn_flaw = release_step(st.mn_flaw, nf, st.flaw_bw[RELEASE_MSB:0], 1'b0);

      // Window extremes; a new window starts from the first sample in it
      if (win_end) begin
        next_st.win_max = (nm > st.win_hi) ? nm : st.win_hi;
        next_st.win_min = (nm < st.win_lo) ? nm : st.win_lo;
        next_st.win_hi = 8'sh80;
        next_st.win_lo = 8'sh7f;
        next_st.win_cnt = 16'h0000;
        lat_set[EV_WINDOW] = 1'b1;
      end else begin
        next_st.win_hi = (nm > st.win_hi) ? nm : st.win_hi;
        next_st.win_lo = (nm < st.win_lo) ? nm : st.win_lo;
        next_st.win_cnt = st.win_cnt + 16'h0001;
      end
    end

    // Loops step once per window on the results of the previous one
    if (win_end && st.loops_ctrl[GAIN_LOOP_BIT]) begin
      if (sat_u8(wamp) < st.thr_lo && st.gain != 4'hf) begin
        next_st.gain = st.gain + 4'h1;
        lat_set[EV_GAIN_STEP] = 1'b1;
      end else if (sat_u8(wamp) > st.thr_hi && st.gain != 4'h0) begin
        next_st.gain = st.gain - 4'h1;
        lat_set[EV_GAIN_STEP] = 1'b1;
      end
    end
    if (win_end && st.loops_ctrl[OFFSET_LOOP_BIT]) begin
      if ($signed(wsum[8:1]) > $signed(st.ofs_bound) && st.ofs_comp != -6'sd32) begin
        next_st.ofs_comp = st.ofs_comp - 6'sd1;
        lat_set[EV_OFS_STEP] = 1'b1;
      end else if ($signed(wsum[8:1]) < -$signed(st.ofs_bound) && st.ofs_comp != 6'sd31) begin
        next_st.ofs_comp = st.ofs_comp + 6'sd1;
        lat_set[EV_OFS_STEP] = 1'b1;
      end
    end

    next_st.flaw_prev = flaw_detected;
    lat_set[EV_FLAW_RISE] = flaw_detected & ~st.flaw_prev;

    // Register bus: answer one cycle after the request, act on the answer edge
    next_st.ack = bus_req & ~st.ack;
    if (in_range && !hosted_hit && off <= OWN_LAST) begin
      unique case (off)
        SAMPLE_CFG: rd = {5'h00, st.sample_cfg};
        DC_REJECT_FILTER_CTRL: rd = st.hpf_ctrl;
        PEAK_MEAS_BANDWIDTH: rd = st.meas_bw;
        FLAW_PATH_BANDWIDTH: rd = st.flaw_bw;
        LEVEL_LOOPS_CTRL: rd = st.loops_ctrl;
        GAIN_THR_LO: rd = st.thr_lo;
        GAIN_THR_HI: rd = st.thr_hi;
        OFFSET_BOUND: rd = st.ofs_bound;
        GAIN_SETTING: rd = {4'h0, st.gain};
        OFFSET_COMP: rd = {{2{st.ofs_comp[5]}}, st.ofs_comp};
        MEAS_MAX: rd = mmax;
        MEAS_MIN: rd = mmin;
        MEAS_AMPLITUDE: rd = sat_u8(mamp);
        MEAS_OFFSET: rd = msum[8:1];
        WIN_MAX: rd = st.win_max;
        WIN_MIN: rd = st.win_min;
        HPF_SAMPLE: rd = st.hpf_q;
        LATCHED_EVENT_FLAGS: rd = {4'h0, st.lat_flags};
        LATCHED_EVENT_MASK: rd = {4'h0, st.lat_mask};
        LIVE_EVENT_FLAGS: rd = {6'h00, st.live_flags};
        LIVE_EVENT_MASK: rd = {6'h00, st.live_mask};
        default: rd = 8'h00;
      endcase
    end else if (hosted_hit) begin
      rd = st.hosted[hosted_idx*8 +: 8];
    end
    if (bus_req && !st.ack) next_st.rdata = rd;

    if (bus_done && in_range && !wb_req.we) begin
      // Clear only what the read returned; an event during the access survives
      if (off == LATCHED_EVENT_FLAGS) lat_clr = st.rdata[3:0];
      if (off == MEAS_AMPLITUDE) live_clr[LV_MEAS_NEW] = 1'b1;
    end
    if (bus_done && in_range && wb_req.we && wb_req.sel[0]) begin
      if (hosted_hit) begin
        next_st.hosted[hosted_idx*8 +: 8] = wbyte;
      end else begin
        unique case (off)
          SAMPLE_CFG: next_st.sample_cfg = wbyte[2:0];
          DC_REJECT_FILTER_CTRL: begin
            next_st.hpf_ctrl = wbyte & ~(8'h01 << HPF_RESET_BIT);
            if (wbyte[HPF_RESET_BIT]) next_st.lp_acc = 20'sh00000;
          end
          PEAK_MEAS_BANDWIDTH: next_st.meas_bw = wbyte;
          FLAW_PATH_BANDWIDTH: next_st.flaw_bw = wbyte;
          LEVEL_LOOPS_CTRL: next_st.loops_ctrl = wbyte;
          GAIN_THR_LO: next_st.thr_lo = wbyte;
          GAIN_THR_HI: next_st.thr_hi = wbyte;
          OFFSET_BOUND: next_st.ofs_bound = wbyte;
          GAIN_SETTING: next_st.gain = wbyte[3:0];
          OFFSET_COMP: next_st.ofs_comp = wbyte[5:0];
          LATCHED_EVENT_MASK: next_st.lat_mask = wbyte[3:0];
          LIVE_EVENT_MASK: next_st.live_mask = wbyte[1:0];
          default: ;
        endcase
      end
    end

    // Set wins over a clear arriving in the same cycle
    next_st.lat_flags = (st.lat_flags & ~lat_clr) | lat_set;
    next_st.live_flags[LV_FLAW] = flaw_detected;
    next_st.live_flags[LV_MEAS_NEW] = (st.live_flags[LV_MEAS_NEW] & ~live_clr[LV_MEAS_NEW])
        | win_end;
    next_st.irq_n = ~(|(st.lat_flags & st.lat_mask) | |(st.live_flags & st.live_mask));
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.sample_cfg <= SAMPLE_CFG_RST;
      st.hpf_ctrl <= HPF_CTRL_RST;
      st.meas_bw <= BW_RST;
      st.flaw_bw <= BW_RST;
      st.loops_ctrl <= LOOPS_RST;
      st.thr_lo <= THR_LO_RST;
      st.thr_hi <= THR_HI_RST;
      st.ofs_bound <= OFS_BOUND_RST;
      st.gain <= GAIN_RST;
      st.win_hi <= 8'sh80;
      st.win_lo <= 8'sh7f;
      st.irq_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign wb_rsp = '{ack: st.ack, dat: {24'h000000, st.rdata}};
  assign sys_tick = st.tick;
  assign hpf_out = st.hpf_q;
  assign flaw_amplitude = sat_u8({st.mx_flaw[28], st.mx_flaw[28:21]}
      - {st.mn_flaw[28], st.mn_flaw[28:21]});
  assign analog_ctrl = '{gain_code: st.gain, offset_code: st.ofs_comp};
  assign hosted_regs = st.hosted;
  assign irq_n = st.irq_n;

endmodule

// ---- dv/rfc_frontend_assertions.sv ----
// Port-level checks for the RF conditioning front end.
module rfc_frontend_assertions import rfc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register bus
  input wire rfc_wb_req_t wb_req,
  input wire rfc_wb_rsp_t wb_rsp,
  // Stream
  input wire logic [5:0] sample_in,
  input wire logic flaw_detected,
  input wire logic sys_tick,
  input wire logic signed [7:0] hpf_out,
  input wire logic [7:0] flaw_amplitude,
  // Controls and interrupt
  input wire rfc_analog_t analog_ctrl,
  input wire logic [HOSTED_WORDS*8-1:0] hosted_regs,
  input wire logic irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  logic req;
  logic wr;
  logic mine;
  logic [11:0] ofs;
  logic [11:0] hofs;
  logic [7:0] lat_m;
  logic [7:0] live_m;
  assign req = wb_req.cyc & wb_req.stb;
  assign wr = req & wb_rsp.ack & wb_req.we & wb_req.sel[0];
  assign mine = wb_req.adr[31:12] == BASE_ADDR[31:12];
  assign ofs = wb_req.adr[11:0];
  assign hofs = ofs - HOSTED_FIRST;
  // Mask shadows; only a written zero is trusted, unimplemented bits may drop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lat_m <= 8'h00;
      live_m <= 8'h00;
    end else if (wr && mine) begin
      if (ofs == LATCHED_EVENT_MASK) lat_m <= wb_req.dat[7:0];
      if (ofs == LIVE_EVENT_MASK) live_m <= wb_req.dat[7:0];
    end
  end
  a_ack_next_cycle: assert property (req && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("request not acknowledged after one cycle");
  a_ack_one_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack stood longer than one cycle");
  a_upper_bits_zero: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_unmapped_read_zero: assert property (
    req && !wb_rsp.ack && !wb_req.we
    && (!mine || ofs > HOSTED_LAST || (ofs > OWN_LAST && ofs < HOSTED_FIRST))
    |=> wb_rsp.dat == 32'h0)
    else $error("unmapped read returned data");
  a_hosted_write: assert property (
    wr && mine && ofs >= HOSTED_FIRST && ofs <= HOSTED_LAST && ofs[1:0] == 2'b00
    |=> hosted_regs[$past(hofs[9:2]) * 8 +: 8] == $past(wb_req.dat[7:0]))
    else $error("hosted byte not written");
  a_gain_written: assert property (
    wr && mine && ofs == GAIN_SETTING |=> analog_ctrl.gain_code == $past(wb_req.dat[3:0]))
    else $error("gain output does not follow write");
  a_offset_written: assert property (
    wr && mine && ofs == OFFSET_COMP |=> analog_ctrl.offset_code == $past(wb_req.dat[5:0]))
    else $error("offset output does not follow write");
  a_irq_all_masked: assert property (lat_m == 8'h00 && live_m == 8'h00 |=> irq_n)
    else $error("interrupt raised with all masks off");
  a_tick_spacing: assert property (sys_tick |=> !sys_tick ##[0:510] sys_tick)
    else $error("system tick spacing out of range");
  a_hpf_on_tick: assert property ($changed(hpf_out) |-> $past(sys_tick))
    else $error("filter output moved without a tick");
  a_flaw_amp_tick: assert property (
    $changed(flaw_amplitude) |-> $past(sys_tick))
    else $error("flaw amplitude moved without a tick");
  a_irq_live_flaw: assert property (
    live_m[0] && flaw_detected ##1 live_m[0] |=> !irq_n)
    else $error("enabled flaw flag did not pull the interrupt low");
endmodule

bind rfc_frontend rfc_frontend_assertions rfc_frontend_assertions_inst (
  .clock(clock),
  .arst_n(arst_n),
  .wb_req(wb_req),
  .wb_rsp(wb_rsp),
  .sample_in(sample_in),
  .flaw_detected(flaw_detected),
  .sys_tick(sys_tick),
  .hpf_out(hpf_out),
  .flaw_amplitude(flaw_amplitude),
  .analog_ctrl(analog_ctrl),
  .hosted_regs(hosted_regs),
  .irq_n(irq_n)
);

// ---- dv/rfc_wb_host.sv ----
// Bus host model: the embedded processor issuing classic Wishbone cycles.
module rfc_wb_host import rfc_pkg::*; (
  // Clock
  input wire logic clock,
  // Register bus
  output rfc_wb_req_t wb_req,
  input wire rfc_wb_rsp_t wb_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial wb_req = '0;
  // Request stands untouched until ack is sampled; the bench timeout ends a hang
  task automatic xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel, output logic [31:0] rdat);
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do @(posedge clock); while (wb_rsp.ack !== 1'b1);
    rdat = wb_rsp.dat;
    wb_req <= '0;
  endtask
endmodule

// ---- dv/rfc_frontend_tb.sv ----
// Self-checking bench for the RF conditioning front end.
module rfc_frontend_tb import rfc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] RST_TAB [12] = '{{SAMPLE_CFG, 5'h00, SAMPLE_CFG_RST},
    {DC_REJECT_FILTER_CTRL, HPF_CTRL_RST}, {PEAK_MEAS_BANDWIDTH, BW_RST},
    {FLAW_PATH_BANDWIDTH, BW_RST}, {LEVEL_LOOPS_CTRL, LOOPS_RST}, {GAIN_THR_LO, THR_LO_RST},
    {GAIN_THR_HI, THR_HI_RST}, {OFFSET_BOUND, OFS_BOUND_RST}, {GAIN_SETTING, 4'h0, GAIN_RST},
    {OFFSET_COMP, 8'h00}, {LATCHED_EVENT_MASK, 8'h00}, {LIVE_EVENT_MASK, 8'h00}};
  localparam logic [31:0] BAD_ADR [4] = '{32'h3000_0250, 32'h3000_029c, 32'h3000_0378,
    32'h3100_02a0};
  localparam int HK [2] = '{53, 0};
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  rfc_wb_req_t wb_req;
  rfc_wb_rsp_t wb_rsp;
  logic [5:0] sample_in = 6'h00;
  logic flaw_detected = 1'b0;
  logic sys_tick;
  logic signed [7:0] hpf_out;
  logic [7:0] flaw_amplitude;
  rfc_analog_t analog_ctrl;
  logic [HOSTED_WORDS*8-1:0] hosted_regs;
  logic irq_n;
  logic rnd_en = 1'b1;
  logic [5:0] fix_smp = 6'h00;
  logic [31:0] rd_dat;
  logic [63:0] exp_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  always #25 clock = ~clock;
  always @(posedge clock) sample_in <= rnd_en ? 6'($urandom) : fix_smp;
  rfc_frontend rfc_frontend_inst (.clock(clock), .arst_n(arst_n), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .sample_in(sample_in), .flaw_detected(flaw_detected),
    .sys_tick(sys_tick), .hpf_out(hpf_out), .flaw_amplitude(flaw_amplitude),
    .analog_ctrl(analog_ctrl), .hosted_regs(hosted_regs), .irq_n(irq_n));
  rfc_wb_host rfc_wb_host_inst (.clock(clock), .wb_req(wb_req), .wb_rsp(wb_rsp));
  task automatic end_of_test();
    if (exp_q.size() != 0) error_cnt++;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] ra(input logic [11:0] o);
    return BASE_ADDR | {20'h0, o};
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    rfc_wb_host_inst.xfer(1'b1, a, d, s, rd_dat);
  endtask
  // Every read notes a mask and an expectation; upper bits are always compared
  task automatic rd(input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({24'hff_ffff, m, 24'h0, e & m});
    rfc_wb_host_inst.xfer(1'b0, a, 32'h0, 4'h1, rd_dat);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clock iff sys_tick === 1'b1);
    repeat (2) @(posedge clock);
  endtask
  task automatic tick_gap(output int n);
    @(posedge clock iff sys_tick === 1'b1);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (sys_tick !== 1'b1);
  endtask
  always @(posedge clock) begin
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) begin
      chk("read data", exp_q[0][31:0], wb_rsp.dat & exp_q[0][63:32]);
      void'(exp_q.pop_front());
    end
  end
  always @(posedge clock) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    logic [7:0] v;
    int n;
    void'($urandom(993));
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    foreach (RST_TAB[i]) rd(ra(RST_TAB[i][19:8]), 8'hff, RST_TAB[i][7:0]);
    for (int k = 0; k < 3; k++) begin
      v = 8'($urandom);
      wr(ra(GAIN_THR_LO + 12'(4 * k)), {24'($urandom), v});
      wr(ra(GAIN_THR_LO + 12'(4 * k)), 32'(~v), 4'he);
      rd(ra(GAIN_THR_LO + 12'(4 * k)), 8'hff, v);
    end
    foreach (HK[i]) begin
      v = 8'($urandom);
      wr(ra(HOSTED_FIRST + 12'(4 * HK[i])), 32'(v));
      rd(ra(HOSTED_FIRST + 12'(4 * HK[i])), 8'hff, v);
      chk("hosted byte", 32'(v), 32'(hosted_regs[HK[i]*8 +: 8]));
    end
    foreach (BAD_ADR[i]) begin
      wr(BAD_ADR[i], 32'hff);
      rd(BAD_ADR[i], 8'hff, 8'h00);
    end
    chk("hosted alias", 32'(v), 32'(hosted_regs[7:0]));
    v = 8'($urandom);
    wr(ra(GAIN_SETTING), 32'(v[3:0]));
    wr(ra(OFFSET_COMP), 32'(v[7:2]));
    rd(ra(GAIN_SETTING), 8'h0f, {4'h0, v[3:0]});
    chk("gain", 32'(v[3:0]), 32'(analog_ctrl.gain_code));
    chk("offset", 32'(v[7:2]), 32'({analog_ctrl.offset_code}));
    rnd_en <= 1'b0;
    for (int d = 0; d < 6; d++) begin
      wr(ra(SAMPLE_CFG), d);
      tick_gap(n);
      tick_gap(n);
      chk("tick gap", 2 << (d > 4 ? 4 : d), n);
    end
    wr(ra(SAMPLE_CFG), 0);
    // Cut-off zero leaves the low-pass at zero, so the output is the averaged input
    wr(ra(DC_REJECT_FILTER_CTRL), 8'h40);
    for (int k = 0; k < 3; k++) begin
      fix_smp <= (k == 0) ? 6'h00 : (k == 1) ? 6'($urandom) : 6'h3f;
      ticks(4);
      chk("hpf out", 32'({fix_smp, 2'b00} ^ 8'h80), 32'({hpf_out}));
    end
    wr(ra(DC_REJECT_FILTER_CTRL), 8'h3f);
    ticks(400);
    chk("hpf settled", 1, 32'(hpf_out < 8 && hpf_out > -8));
    wr(ra(DC_REJECT_FILTER_CTRL), 8'h7f);
    ticks(1);
    chk("hpf cleared", 1, 32'(hpf_out > 100));
    flaw_detected <= 1'b1;
    wr(ra(DC_REJECT_FILTER_CTRL), 8'hff);
    ticks(50);
    chk("hpf held", 32'h7c, 32'({hpf_out}));
    rd(ra(LIVE_EVENT_FLAGS), 8'h01, 8'h01);
    chk("irq masked", 1, 32'(irq_n));
    wr(ra(LIVE_EVENT_MASK), 8'h01);
    repeat (2) @(posedge clock);
    chk("irq live", 0, 32'(irq_n));
    flaw_detected <= 1'b0;
    repeat (3) @(posedge clock);
    chk("irq live off", 1, 32'(irq_n));
    wr(ra(LIVE_EVENT_MASK), 8'h00);
    rd(ra(LATCHED_EVENT_FLAGS), 8'h00, 8'h00);
    wr(ra(LATCHED_EVENT_MASK), 8'h02);
    flaw_detected <= 1'b1;
    repeat (3) @(posedge clock);
    flaw_detected <= 1'b0;
    repeat (3) @(posedge clock);
    chk("irq latched", 0, 32'(irq_n));
    rd(ra(LATCHED_EVENT_FLAGS), 8'h02, 8'h02);
    repeat (2) @(posedge clock);
    chk("irq cleared", 1, 32'(irq_n));
    rd(ra(LATCHED_EVENT_FLAGS), 8'h02, 8'h00);
    wr(ra(DC_REJECT_FILTER_CTRL), 8'h40);
    wr(ra(LEVEL_LOOPS_CTRL), 8'h0a);
    // Fastest release so the minimum climbs from the earlier floor within the wait
    wr(ra(PEAK_MEAS_BANDWIDTH), 8'h00);
    repeat (2200) @(posedge clock);
    rd(ra(LIVE_EVENT_FLAGS), 8'h02, 8'h02);
    rd(ra(MEAS_AMPLITUDE), 8'hff, 8'h00);
    rd(ra(LIVE_EVENT_FLAGS), 8'h02, 8'h00);
    rd(ra(MEAS_MAX), 8'hff, 8'h7c);
    rd(ra(MEAS_MIN), 8'hff, 8'h7c);
    rd(ra(MEAS_OFFSET), 8'hff, 8'h7c);
    rd(ra(WIN_MAX), 8'hff, 8'h7c);
    rd(ra(WIN_MIN), 8'hff, 8'h7c);
    repeat (2) @(posedge clock);
    end_of_test();
  end
endmodule
